// File: common/stu_pkg.sv
package stu_pkg;

  localparam int REG_W = 16;
  localparam int ADDR_W = 6;

  // Register numbers as carried in the control byte
  localparam logic [ADDR_W-1:0] ADDR_WORD2_SEL  = 6'h27;
  localparam logic [ADDR_W-1:0] ADDR_LOGIC_CFG  = 6'h28;
  localparam logic [ADDR_W-1:0] ADDR_SRC_THR    = 6'h29;
  localparam logic [ADDR_W-1:0] ADDR_ARM_THR    = 6'h2a;
  localparam logic [ADDR_W-1:0] ADDR_GLITCH_W   = 6'h2b;
  localparam logic [ADDR_W-1:0] ADDR_VALID_WIN  = 6'h2c;

  localparam logic [REG_W-1:0] WORD2_SEL_RST = 16'h8010;
  localparam logic [REG_W-1:0] LOGIC_CFG_RST = 16'h0c01;
  localparam logic [REG_W-1:0] ZERO_WORD     = 16'h0000;
  localparam logic [REG_W-1:0] ONE_WORD      = 16'h0001;
  localparam logic [REG_W-1:0] MAX_WORD      = 16'hffff;

  // Control byte layout
  localparam int CTRL_REG_COMM_BIT   = 7;
  localparam int CTRL_WRITE_BIT      = 6;
  localparam int CTRL_OUT_PERMIT_BIT = 2;
  localparam int CTRL_ONE_SHOT_BIT   = 0;

  // Selector codes served inside this block
  localparam logic [REG_W-1:0] IDX_ANALOG = 16'h0000;
  localparam logic [REG_W-1:0] IDX_LATCH  = 16'h000e;
  localparam logic [REG_W-1:0] IDX_TIMER  = 16'h000f;

  // Sample period and derived divider count
  localparam int SAMPLE_PERIOD_US  = 200;
  localparam int CLK_PERIOD_NS     = 4;
  localparam int SAMPLE_DIV_CYCLES = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ARM_ALWAYS   = 3'b000,
    ARM_A_ABOVE  = 3'b001,
    ARM_A_BELOW  = 3'b010,
    ARM_B_ABOVE  = 3'b011,
    ARM_B_BELOW  = 3'b100,
    ARM_EXT_HIGH = 3'b101,
    ARM_EXT_LOW  = 3'b110,
    ARM_RSVD     = 3'b111
  } stu_arm_e;

  typedef enum logic [1:0] {
    ORG_TIMER   = 2'b00,
    ORG_CHAN_A  = 2'b01,
    ORG_CHAN_B  = 2'b10,
    ORG_DIGITAL = 2'b11
  } stu_origin_e;

  typedef enum logic [1:0] {
    MODE_SHOT   = 2'b00,
    MODE_EDGE   = 2'b01,
    MODE_GLITCH = 2'b10,
    MODE_RSVD   = 2'b11
  } stu_mode_e;

  typedef enum logic [1:0] {
    WIN_IDLE = 2'b01,
    WIN_OPEN = 2'b10
  } stu_win_e;

  typedef struct packed {
    logic        rsvd15;
    stu_arm_e    arm_condition_select;
    stu_origin_e trigger_origin_select;
    stu_mode_e   mode;
    logic        rsvd7;
    logic        chain_window_enable;
    logic        begin_capture_select;
    logic        output_on_event;
    logic        timer_capture_on_event;
    logic        timer_clear_on_event;
    logic        width_compare_longer;
    logic        edge_polarity;
  } stu_logic_cfg_s;

endpackage

// File: core/stu_trigger_unit.sv
`timescale 1ns/1ns
module stu_trigger_unit
  import stu_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_DIV_CYCLES
)
(
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic [7:0]        i_ctrl_byte,
  input  wire logic [REG_W-1:0]  i_output_word,
  input  wire logic [REG_W-1:0]  i_analog_channel_a,
  input  wire logic [REG_W-1:0]  i_analog_channel_b,
  input  wire logic              i_ext_trigger,
  input  wire logic              i_digital_input,
  input  wire logic              i_chain_condition,
  input  wire logic [REG_W-1:0]  i_record_word,
  output logic [7:0]             o_status_byte,
  output logic [REG_W-1:0]       o_input_word2,
  output logic [REG_W-1:0]       o_word2_index,
  output logic                   o_sample_tick,
  output logic                   o_trigger_event,
  output logic                   o_downstream_enable,
  output logic                   o_start_capture,
  output logic                   o_digital_output,
  output logic                   o_chain_reset
);

  localparam int DIV_W = $clog2(SAMPLE_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_above(input logic [REG_W-1:0] v, input logic [REG_W-1:0] t);
    is_above = $signed(v) > $signed(t);
  endfunction

  function automatic logic is_below(input logic [REG_W-1:0] v, input logic [REG_W-1:0] t);
    is_below = $signed(v) < $signed(t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [REG_W-1:0] word2_sel, logic_cfg, src_thr, arm_thr, glitch_w, valid_win;
  logic [REG_W-1:0] next_word2_sel, next_logic_cfg, next_src_thr;
  logic [REG_W-1:0] next_arm_thr, next_glitch_w, next_valid_win;
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic [REG_W-1:0] timer, next_timer, timer_latch, next_timer_latch;
  logic [REG_W-1:0] pulse_len, next_pulse_len, win_cnt, next_win_cnt;
  logic             src_prev, next_src_prev, shot_prev, next_shot_prev;
  logic             hist_valid, next_hist_valid, shot_valid, next_shot_valid;
  stu_win_e         win_state, next_win_state;
  logic [7:0]       next_status_byte;
  logic [REG_W-1:0] next_input_word2;
  logic             next_sample_tick, next_trigger_event, next_downstream_enable;
  logic             next_start_capture, next_digital_output, next_chain_reset;

  stu_logic_cfg_s   cfg;
  logic             tick, reg_comm, armed, src_level, active, prev_active;
  logic             shot_hit, edge_hit, glitch_hit, fire;
  logic [ADDR_W-1:0] reg_addr;
  logic [REG_W-1:0] reg_rd;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cfg      = stu_logic_cfg_s'(logic_cfg);
    tick     = (div_cnt == DIV_LAST);
    reg_comm = i_ctrl_byte[CTRL_REG_COMM_BIT];
    reg_addr = i_ctrl_byte[ADDR_W-1:0];

    // Arming condition
    unique case (cfg.arm_condition_select)
      ARM_ALWAYS:   armed = 1'b1;
      ARM_A_ABOVE:  armed = is_above(i_analog_channel_a, arm_thr);
      ARM_A_BELOW:  armed = is_below(i_analog_channel_a, arm_thr);
      ARM_B_ABOVE:  armed = is_above(i_analog_channel_b, arm_thr);
      ARM_B_BELOW:  armed = is_below(i_analog_channel_b, arm_thr);
      ARM_EXT_HIGH: armed = i_ext_trigger;
      ARM_EXT_LOW:  armed = !i_ext_trigger;
      ARM_RSVD:     armed = 1'b0;
    endcase

    // Source level against threshold 1; timer compares unsigned
    unique case (cfg.trigger_origin_select)
      ORG_TIMER:   src_level = timer > src_thr;
      ORG_CHAN_A:  src_level = is_above(i_analog_channel_a, src_thr);
      ORG_CHAN_B:  src_level = is_above(i_analog_channel_b, src_thr);
      ORG_DIGITAL: src_level = i_digital_input;
    endcase

    active      = cfg.edge_polarity ? src_level : !src_level;
    prev_active = cfg.edge_polarity ? src_prev : !src_prev;

    // Shot edges are only meaningful while the control byte carries control bits
    // No edge until a history exists, so leaving reset cannot fake one
    shot_hit   = !reg_comm && shot_valid &&
                 (i_ctrl_byte[CTRL_ONE_SHOT_BIT] != shot_prev);
    edge_hit   = tick && hist_valid && active && !prev_active;
    glitch_hit = tick && hist_valid && !active && prev_active && (cfg.width_compare_longer ?
                 (pulse_len > glitch_w) : (pulse_len < glitch_w));

    unique case (cfg.mode)
      MODE_SHOT:   fire = armed && shot_hit;
      MODE_EDGE:   fire = armed && edge_hit;
      MODE_GLITCH: fire = armed && glitch_hit;
      MODE_RSVD:   fire = 1'b0;
    endcase

    unique case (reg_addr)
      ADDR_WORD2_SEL: reg_rd = word2_sel;
      ADDR_LOGIC_CFG: reg_rd = logic_cfg;
      ADDR_SRC_THR:   reg_rd = src_thr;
      ADDR_ARM_THR:   reg_rd = arm_thr;
      ADDR_GLITCH_W:  reg_rd = glitch_w;
      ADDR_VALID_WIN: reg_rd = valid_win;
      default:        reg_rd = ZERO_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file over process-data register communication
  always_comb
  begin
    next_word2_sel = word2_sel;
    next_logic_cfg = logic_cfg;
    next_src_thr   = src_thr;
    next_arm_thr   = arm_thr;
    next_glitch_w  = glitch_w;
    next_valid_win = valid_win;
    if (reg_comm && i_ctrl_byte[CTRL_WRITE_BIT])
    begin
      unique case (reg_addr)
        ADDR_WORD2_SEL: next_word2_sel = i_output_word;
        ADDR_LOGIC_CFG: next_logic_cfg = i_output_word;
        ADDR_SRC_THR:   next_src_thr   = i_output_word;
        ADDR_ARM_THR:   next_arm_thr   = i_output_word;
        ADDR_GLITCH_W:  next_glitch_w  = i_output_word;
        ADDR_VALID_WIN: next_valid_win = i_output_word;
        default:        next_word2_sel = word2_sel;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      word2_sel <= WORD2_SEL_RST;
      logic_cfg <= LOGIC_CFG_RST;
      src_thr   <= ZERO_WORD;
      arm_thr   <= ZERO_WORD;
      glitch_w  <= ZERO_WORD;
      valid_win <= ZERO_WORD;
    end
    else
    begin
      word2_sel <= next_word2_sel;
      logic_cfg <= next_logic_cfg;
      src_thr   <= next_src_thr;
      arm_thr   <= next_arm_thr;
      glitch_w  <= next_glitch_w;
      valid_win <= next_valid_win;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample divider, timer, source history
  always_comb
  begin
    next_div_cnt     = tick ? DIV_ZERO : div_cnt + DIV_W'(1);
    next_timer       = tick ? timer + ONE_WORD : timer;
    next_timer_latch = timer_latch;
    if (fire && cfg.timer_capture_on_event)
      next_timer_latch = timer;
    // Clear wins over the count; counting resumes on the next sample
    if (fire && cfg.timer_clear_on_event)
      next_timer = ZERO_WORD;
    next_src_prev  = tick ? src_level : src_prev;
    next_shot_prev = reg_comm ? shot_prev : i_ctrl_byte[CTRL_ONE_SHOT_BIT];
    next_hist_valid = hist_valid || tick;
    next_shot_valid = shot_valid || !reg_comm;
    next_pulse_len = pulse_len;
    if (tick)
    begin
      if (!active)
        next_pulse_len = ZERO_WORD;
      else if (pulse_len != MAX_WORD)
        next_pulse_len = pulse_len + ONE_WORD;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      div_cnt     <= DIV_ZERO;
      timer       <= ZERO_WORD;
      timer_latch <= ZERO_WORD;
      src_prev    <= 1'b0;
      shot_prev   <= 1'b0;
      pulse_len   <= ZERO_WORD;
      hist_valid  <= 1'b0;
      shot_valid  <= 1'b0;
    end
    else
    begin
      div_cnt     <= next_div_cnt;
      timer       <= next_timer;
      timer_latch <= next_timer_latch;
      src_prev    <= next_src_prev;
      shot_prev   <= next_shot_prev;
      pulse_len   <= next_pulse_len;
      hist_valid  <= next_hist_valid;
      shot_valid  <= next_shot_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event actions and valid-trigger window
  always_comb
  begin
    next_win_state         = win_state;
    next_win_cnt           = win_cnt;
    next_chain_reset       = 1'b0;
    next_downstream_enable = o_downstream_enable;
    next_start_capture     = fire && cfg.begin_capture_select;
    next_trigger_event     = fire;
    next_sample_tick       = tick;
    next_digital_output = o_digital_output;
    if (!i_ctrl_byte[CTRL_OUT_PERMIT_BIT] || reg_comm)
      next_digital_output = reg_comm ? o_digital_output : 1'b0;
    if (fire && cfg.output_on_event && !reg_comm && i_ctrl_byte[CTRL_OUT_PERMIT_BIT])
      next_digital_output = 1'b1;
    unique case (win_state)
      WIN_IDLE:
      begin
        if (fire && cfg.chain_window_enable && !cfg.begin_capture_select)
        begin
          next_win_state = WIN_OPEN;
          next_win_cnt   = valid_win;
        end
      end
      WIN_OPEN:
      begin
        if (i_chain_condition)
          next_win_state = WIN_IDLE;
        else if (tick)
        begin
          if (win_cnt == ZERO_WORD)
          begin
            // Late answer from the next unit tears the chain back down
            next_win_state         = WIN_IDLE;
            next_chain_reset       = 1'b1;
            next_downstream_enable = 1'b0;
          end
          else
            next_win_cnt = win_cnt - ONE_WORD;
        end
      end
      default:
        next_win_state = WIN_IDLE;
    endcase
    // A fresh event outranks a window expiry in the same cycle at downstream enable only; the expiry still pulses chain reset
    if (fire && !cfg.begin_capture_select)
      next_downstream_enable = 1'b1;
    next_status_byte = i_ctrl_byte;
    if (reg_comm)
      next_input_word2 = reg_rd;
    else if (word2_sel == IDX_ANALOG)
      next_input_word2 = i_analog_channel_a;
    else if (word2_sel == IDX_LATCH)
      next_input_word2 = timer_latch;
    else if (word2_sel == IDX_TIMER)
      next_input_word2 = timer;
    else
      next_input_word2 = i_record_word;
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      win_state           <= WIN_IDLE;
      win_cnt             <= ZERO_WORD;
      o_status_byte       <= 8'h00;
      o_input_word2       <= ZERO_WORD;
      o_word2_index       <= WORD2_SEL_RST;
      o_sample_tick       <= 1'b0;
      o_trigger_event     <= 1'b0;
      o_downstream_enable <= 1'b0;
      o_start_capture     <= 1'b0;
      o_digital_output    <= 1'b0;
      o_chain_reset       <= 1'b0;
    end
    else
    begin
      win_state           <= next_win_state;
      win_cnt             <= next_win_cnt;
      o_status_byte       <= next_status_byte;
      o_input_word2       <= next_input_word2;
      o_word2_index       <= next_word2_sel;
      o_sample_tick       <= next_sample_tick;
      o_trigger_event     <= next_trigger_event;
      o_downstream_enable <= next_downstream_enable;
      o_start_capture     <= next_start_capture;
      o_digital_output    <= next_digital_output;
      o_chain_reset       <= next_chain_reset;
    end
  end

endmodule

// File: verif/stu_trigger_checker_properties.sv
`timescale 1ns/1ns
module stu_trigger_checker
  import stu_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_DIV_CYCLES
)
(
  input wire logic             i_clk,
  input wire logic             i_reset,
  input wire logic [7:0]       i_ctrl_byte,
  input wire logic [REG_W-1:0] i_output_word,
  input wire logic [REG_W-1:0] o_input_word2,
  input wire logic [REG_W-1:0] o_word2_index,
  input wire logic             o_sample_tick,
  input wire logic             o_trigger_event,
  input wire logic             o_downstream_enable,
  input wire logic             o_start_capture,
  input wire logic             o_digital_output,
  input wire logic             o_chain_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////////
  // Sample-counted times are only as good as the tick spacing
  int   gap;
  int   next_gap;
  logic seen;
  logic next_seen;
  always_comb
  begin
    next_gap  = o_sample_tick ? 0 : gap + 1;
    next_seen = seen | o_sample_tick;
  end
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      gap  <= 0;
      seen <= 1'b0;
    end
    else
    begin
      gap  <= next_gap;
      seen <= next_seen;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_word2_track: assert property (
    (i_ctrl_byte[7:6] == 2'b11 && i_ctrl_byte[5:0] == ADDR_WORD2_SEL)
    |=> o_word2_index == $past(i_output_word)) else $error("selector copy stale");
  a_word2_read: assert property (
    (i_ctrl_byte[7:6] == 2'b10 && i_ctrl_byte[5:0] == ADDR_WORD2_SEL)
    |=> o_input_word2 == $past(o_word2_index)) else $error("selector read wrong");
  a_capture_event: assert property (
    o_start_capture |-> o_trigger_event) else $error("capture without event");
  a_down_on_event: assert property (
    o_trigger_event && !o_start_capture |-> o_downstream_enable)
    else $error("downstream not enabled");
  a_down_fall: assert property (
    $fell(o_downstream_enable) |-> (o_chain_reset || $past(o_chain_reset)))
    else $error("downstream dropped without chain reset");
  a_chain_pulse: assert property (
    o_chain_reset |=> !o_chain_reset) else $error("chain reset not a pulse");
  a_chain_cause: assert property (
    o_chain_reset |-> $past(o_downstream_enable)) else $error("chain reset unprompted");
  a_out_permit: assert property (
    (!i_ctrl_byte[7] && !i_ctrl_byte[2]) |=> !o_digital_output)
    else $error("output set without permit");
  a_out_cause: assert property (
    $rose(o_digital_output) |-> o_trigger_event && $past(i_ctrl_byte[2]))
    else $error("output rose without event");
  a_tick_spacing: assert property (
    o_sample_tick && seen |-> gap == SAMPLE_DIV - 1) else $error("tick spacing wrong");
endmodule
bind stu_trigger_unit stu_trigger_checker #(.SAMPLE_DIV(SAMPLE_DIV)) chk_u (
  .i_clk              (i_clk),
  .i_reset            (i_reset),
  .i_ctrl_byte        (i_ctrl_byte),
  .i_output_word      (i_output_word),
  .o_input_word2      (o_input_word2),
  .o_word2_index      (o_word2_index),
  .o_sample_tick      (o_sample_tick),
  .o_trigger_event    (o_trigger_event),
  .o_downstream_enable(o_downstream_enable),
  .o_start_capture    (o_start_capture),
  .o_digital_output   (o_digital_output),
  .o_chain_reset      (o_chain_reset)
);

// File: verif/stu_ctrl_model.sv
`timescale 1ns/1ns
module stu_ctrl_model
  import stu_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic [7:0]       i_status_byte,
  input  wire logic [REG_W-1:0] i_input_word2,
  output logic      [7:0]       o_ctrl_byte,
  output logic      [REG_W-1:0] o_output_word
);
  logic [7:0] idle = 8'h00;
  initial o_ctrl_byte = 8'h00;
  initial o_output_word = 16'h0000;
  // Request held across one rising edge, answer taken a cycle later
  task automatic xfer(input logic [7:0] c, input logic [REG_W-1:0] d,
                      output logic [7:0] s, output logic [REG_W-1:0] q);
    @(negedge i_clk);
    o_ctrl_byte = c;
    o_output_word = d;
    @(negedge i_clk);
    s = i_status_byte;
    q = i_input_word2;
    o_ctrl_byte = idle;
    // Word means nothing between requests, so never leave it looking valid
    o_output_word = ~d;
  endtask
  task automatic set_idle(input logic [7:0] c);
    @(negedge i_clk);
    idle = c;
    o_ctrl_byte = c;
  endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ns
module testbench
  import stu_pkg::*;
;
  localparam int DIV = 4;
  logic             i_clk = 1'b0;
  logic             i_reset = 1'b1;
  logic [REG_W-1:0] ana_a = 16'h0000;
  logic [REG_W-1:0] ana_b = 16'h0000;
  logic             ext = 1'b1;
  logic             dig = 1'b0;
  logic             chain = 1'b0;
  logic             shot = 1'b0;
  logic             perm = 1'b0;
  logic [7:0]       ctrl, stat;
  logic [REG_W-1:0] word, w2, idx;
  logic             tick, evt, down, cap, dout, crst;
  int n_errors = 0, samples_checked = 0, n_evt = 0, n_cap = 0, n_crst = 0, cyc = 0;
  always #2 i_clk = ~i_clk;
  stu_trigger_unit #(.SAMPLE_DIV(DIV)) dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_ctrl_byte(ctrl), .i_output_word(word),
    .i_analog_channel_a(ana_a), .i_analog_channel_b(ana_b), .i_ext_trigger(ext),
    .i_digital_input(dig), .i_chain_condition(chain), .i_record_word(16'h5a5a),
    .o_status_byte(stat), .o_input_word2(w2), .o_word2_index(idx), .o_sample_tick(tick),
    .o_trigger_event(evt), .o_downstream_enable(down), .o_start_capture(cap),
    .o_digital_output(dout), .o_chain_reset(crst));
  stu_ctrl_model ctl_u (.i_clk(i_clk), .i_status_byte(stat), .i_input_word2(w2),
    .o_ctrl_byte(ctrl), .o_output_word(word));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk)
  begin
    cyc++;
    n_evt += (evt === 1'b1);
    n_cap += (cap === 1'b1);
    n_crst += (crst === 1'b1);
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [REG_W-1:0] e);
    logic [7:0] s;
    logic [REG_W-1:0] q;
    ctl_u.xfer({2'b10, a}, ZERO_WORD, s, q);
    chk(s, {2'b10, a});
    chk(q, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [REG_W-1:0] d);
    logic [7:0] s;
    logic [REG_W-1:0] q;
    ctl_u.xfer({2'b11, a}, d, s, q);
  endtask
  task automatic clr();
    n_evt = 0;
    n_cap = 0;
    n_crst = 0;
  endtask
  task automatic cnt(input int n, input int e, input int c, input int r);
    repeat (n) @(negedge i_clk);
    chk(n_evt, e);
    chk(n_cap, c);
    chk(n_crst, r);
  endtask
  // Settle first so leaving register mode cannot pass for a shot edge
  task automatic fire();
    repeat (3) @(negedge i_clk);
    shot = ~shot;
    ctl_u.set_idle({5'b0, perm, 1'b0, shot});
    clr();
  endtask
  task automatic rst();
    i_reset = 1'b1;
    repeat (8) @(negedge i_clk);
    i_reset = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst();
    rd(ADDR_WORD2_SEL, WORD2_SEL_RST);
    chk(idx, WORD2_SEL_RST);
    rd(ADDR_LOGIC_CFG, LOGIC_CFG_RST);
    for (int k = 0; k < 6; k++) wr(ADDR_WORD2_SEL + 6'(k), 16'h1111 * 16'(k + 1));
    for (int k = 0; k < 6; k++) rd(ADDR_WORD2_SEL + 6'(k), 16'h1111 * 16'(k + 1));
    rd(6'h30, ZERO_WORD);
    ana_a = 16'h0123;
    wr(ADDR_WORD2_SEL, IDX_ANALOG);
    repeat (3 * DIV) @(negedge i_clk);
    chk(w2, 16'h0123);
    wr(ADDR_WORD2_SEL, WORD2_SEL_RST);
    repeat (2) @(negedge i_clk);
    chk(w2, 16'h5a5a);
    rst();
    wr(ADDR_ARM_THR, 16'h0100);
    // Second pass flips every arming input so codes 1 to 6 are each seen both ways
    for (int p = 0; p < 2; p++)
    begin
      ana_a = p ? ZERO_WORD : 16'h0200;
      ana_b = p ? 16'h0200 : ZERO_WORD;
      ext   = (p == 0);
      for (int c = 0; c < 8; c++)
      begin
        wr(ADDR_LOGIC_CFG, {1'b0, 3'(c), 12'hc01});
        fire();
        cnt(DIV, ((p ? 8'h4d : 8'h33) >> c) & 1, 0, 0);
      end
    end
    rst();
    wr(ADDR_LOGIC_CFG, 16'h0d01);
    repeat (3 * DIV) @(negedge i_clk);
    clr();
    dig = 1'b1;
    cnt(3 * DIV, 1, 0, 0);
    chk(down, 1'b1);
    dig = 1'b0;
    cnt(3 * DIV, 1, 0, 0);
    wr(ADDR_LOGIC_CFG, 16'h0d00);
    repeat (3 * DIV) @(negedge i_clk);
    clr();
    dig = 1'b1;
    cnt(3 * DIV, 0, 0, 0);
    dig = 1'b0;
    cnt(3 * DIV, 1, 0, 0);
    ana_a = ZERO_WORD;
    rst();
    wr(ADDR_SRC_THR, 16'h0100);
    wr(ADDR_LOGIC_CFG, 16'h0501);
    clr();
    ana_a = 16'h0100;
    cnt(3 * DIV, 0, 0, 0);
    ana_a = 16'h0101;
    cnt(3 * DIV, 1, 0, 0);
    rst();
    wr(ADDR_WORD2_SEL, IDX_TIMER);
    repeat (10 * DIV) @(negedge i_clk);
    chk(w2 >= 16'h0009 && w2 <= 16'h000b, 1'b1);
    wr(ADDR_SRC_THR, 16'h0040);
    wr(ADDR_WORD2_SEL, IDX_LATCH);
    wr(ADDR_LOGIC_CFG, 16'h010d);
    for (int i = 0; i < 1000 && evt !== 1'b1; i++) @(negedge i_clk);
    repeat (2) @(negedge i_clk);
    chk(w2 == 16'h0041 || w2 == 16'h0042, 1'b1);
    clr();
    cnt(300, 1, 0, 0);
    rst();
    perm = 1'b1;
    wr(ADDR_LOGIC_CFG, 16'h0c31);
    fire();
    cnt(DIV, 1, 1, 0);
    chk(down, 1'b0);
    chk(dout, 1'b1);
    perm = 1'b0;
    ctl_u.set_idle({5'b0, perm, 1'b0, shot});
    repeat (2) @(negedge i_clk);
    chk(dout, 1'b0);
    rst();
    wr(ADDR_VALID_WIN, 16'h0002);
    wr(ADDR_LOGIC_CFG, 16'h0c41);
    fire();
    cnt(8 * DIV, 1, 0, 1);
    chk(down, 1'b0);
    chain = 1'b1;
    fire();
    cnt(8 * DIV, 1, 0, 0);
    chk(down, 1'b1);
    chain = 1'b0;
    rst();
    wr(ADDR_GLITCH_W, 16'h0003);
    for (int g = 0; g < 4; g++)
    begin
      wr(ADDR_LOGIC_CFG, g < 2 ? 16'h0e03 : 16'h0e01);
      repeat (3 * DIV) @(negedge i_clk);
      clr();
      dig = 1'b1;
      repeat (g[0] ? DIV : 6 * DIV) @(negedge i_clk);
      dig = 1'b0;
      cnt(3 * DIV, g == 0 || g == 3, 0, 0);
    end
    report_and_stop();
  end
endmodule
